// ### verilog/multiplier_register_moves.sv
// executes the multiplier register move group of the core
// assumes: core fetch/address logic on clk_sys_in supplies opcode, operand and pc
// Behaviour
// - store multiplicand upper half, 16 bits, to the operand location
// - store into accumulator half sets negative from bit 15, zero if half zero
// - non-repeatable moves after repeat prefix clear repeat count, run once
// - load overflow count from operand bits 15:10, mode 1 only, no flags
// - load product upper half from operand, lower kept, no flags, one cycle
// - load product lower half from operand, upper kept, no flags, one cycle
// - load shift setting from low three bits of accumulator half, mode 1
// - load multiplicand upper half from operand, no flags, one cycle
// - clear multiplicand lower half, upper kept, mode 1 only, no flags
// - aux pointer register gets zero-extended 22-bit program counter, mode 1
// - load-multiply-add is repeatable: count N gives N+1 executions, N+1 cycles
// - load-multiply-add also adds shifted product to accumulator
// - left shift fills zeros, right shift sign-extends the product
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module multiplier_register_moves (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_word_in,
  input wire logic [15:0] instr_ext_in,
  input wire logic [1:0] loc_target_in,
  input wire logic [15:0] operand_data_in,
  input wire logic [21:0] pc_in,
  input wire logic rpt_load_in,
  input wire logic [7:0] rpt_count_in,
  output logic instr_ready_out,
  output logic mem_wr_out,
  output logic [15:0] mem_wdata_out,
  output logic neg_flag_out,
  output logic zero_flag_out,
  output logic carry_flag_out,
  output logic ovf_flag_out,
  output logic exec_done_out,
  output logic illegal_out,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);
  mul_move_pkg::exec_state_e state_q, state_d;
  logic ready_q, mode_q, wait_q, mem_wr_q, done_q, illegal_q;
  logic n_q, z_q, c_q, v_q;
  logic [7:0] rpt_q;
  logic [15:0] mem_wdata_q;
  logic [31:0] acc_q, prod_q, mul_q, rdata_q;
  logic [2:0] shift_q;
  logic [5:0] ovf_q;
  logic [31:0] aux_q [8];

  // select one accumulator half
  function automatic logic [15:0] half_of(input logic [31:0] w, input logic upper);
    half_of = upper ? w[31:16] : w[15:0];
  endfunction

  // product as seen by the adder under the shift setting
  function automatic logic [31:0] prod_shift(input logic [31:0] p, input logic [2:0] s);
    if (s == mul_move_pkg::SHIFT_LEFT1) begin
      prod_shift = {p[30:0], 1'b0};
    end else begin
      prod_shift = $signed(p) >>> (s - mul_move_pkg::SHIFT_NONE);
    end
  endfunction

  // byte-lane merge for bus writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // opcode decode
  logic is_st, is_ph, is_pl, is_t, is_load_mul_add_op, is_ovc, is_pm, is_tl, is_pc;
  logic needs_mode, known, accept, bad, go, load_mul_add_op_go;
  assign is_st = instr_word_in[15:8] == mul_move_pkg::OP_STORE_MUL_HI;
  assign is_ph = instr_word_in[15:8] == mul_move_pkg::OP_LOAD_PROD_HI;
  assign is_pl = instr_word_in[15:8] == mul_move_pkg::OP_LOAD_PROD_LO;
  assign is_t = instr_word_in[15:8] == mul_move_pkg::OP_LOAD_MUL_HI;
  assign is_load_mul_add_op = instr_word_in[15:8] == mul_move_pkg::OP_LOAD_MUL_ADD;
  assign is_ovc = instr_word_in == mul_move_pkg::OP_LOAD_OVF
                  && instr_ext_in[15:8] == mul_move_pkg::EXT_PREFIX;
  assign is_pm = instr_word_in[15:1] == mul_move_pkg::OP_LOAD_SHIFT;
  assign is_tl = instr_word_in == mul_move_pkg::OP_CLR_MUL_LO;
  assign is_pc = instr_word_in[15:3] == mul_move_pkg::OP_SAVE_PC;
  assign needs_mode = is_ovc | is_pm | is_tl | is_pc;
  assign known = is_st | is_ph | is_pl | is_t | is_load_mul_add_op | needs_mode;
  assign accept = instr_valid_in & ready_q;
  assign bad = !known || (needs_mode && !mode_q);
  assign go = accept & !bad;
  assign load_mul_add_op_go = (go & is_load_mul_add_op) | (state_q == mul_move_pkg::ST_REPEAT);

  // operand value: memory word or an accumulator half
  logic [15:0] src16;
  logic loc_acc;
  assign loc_acc = loc_target_in != mul_move_pkg::LOC_MEM;
  assign src16 = loc_acc ? half_of(acc_q, loc_target_in == mul_move_pkg::LOC_ACC_UPPER)
                         : operand_data_in;

  // accumulator half named by the opcode for the shift-setting load
  logic [15:0] pm_src;
  assign pm_src = half_of(acc_q, instr_word_in[mul_move_pkg::HALF_SEL_BIT]);

  // accumulate path
  logic [31:0] shp, sum;
  logic carry, ovf;
  assign shp = prod_shift(prod_q, shift_q);
  assign {carry, sum} = {1'b0, acc_q} + {1'b0, shp};
  assign ovf = (acc_q[31] == shp[31]) && (sum[31] != acc_q[31]);

  // repeat sequencer: leave once the count has run down to zero, giving n+1 passes
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mul_move_pkg::ST_IDLE: begin
        if (go && is_load_mul_add_op && rpt_q != 8'h00) begin
          state_d = mul_move_pkg::ST_REPEAT;
        end
      end
      mul_move_pkg::ST_REPEAT: begin
        if (rpt_q == 8'h00) begin
          state_d = mul_move_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= mul_move_pkg::ST_IDLE;
      ready_q <= 1'b0;
      rpt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      ready_q <= state_d == mul_move_pkg::ST_IDLE;
      if (load_mul_add_op_go && rpt_q != 8'h00) begin
        rpt_q <= rpt_q - 8'h01;
      end else if (accept) begin
        rpt_q <= 8'h00;
      end else if (rpt_load_in && state_q == mul_move_pkg::ST_IDLE) begin
        rpt_q <= rpt_count_in;
      end
    end
  end

  // multiplier-side registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prod_q <= mul_move_pkg::WORD_RESET;
      mul_q <= mul_move_pkg::WORD_RESET;
      shift_q <= mul_move_pkg::SHIFT_RESET;
      ovf_q <= mul_move_pkg::OVF_RESET;
    end else begin
      if (go && is_ph) begin
        prod_q[31:16] <= src16;
      end
      if (go && is_pl) begin
        prod_q[15:0] <= src16;
      end
      if (go && is_pm) begin
        shift_q <= pm_src[2:0];
      end
      if ((go && is_t) || load_mul_add_op_go) begin
        mul_q[31:16] <= src16;
      end
      if (go && is_tl) begin
        mul_q[15:0] <= mul_move_pkg::HALF_ZERO;
      end
      if (go && is_ovc) begin
        ovf_q <= src16[mul_move_pkg::OVF_MSB:mul_move_pkg::OVF_LSB];
      end else if (load_mul_add_op_go && ovf) begin
        ovf_q <= acc_q[31] ? ovf_q - 6'h01 : ovf_q + 6'h01;
      end
    end
  end

  // accumulator, flags and software writes to the accumulator
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      acc_q <= mul_move_pkg::WORD_RESET;
      {n_q, z_q, c_q, v_q} <= 4'h0;
    end else if (load_mul_add_op_go) begin
      acc_q <= sum;
      n_q <= sum[31];
      z_q <= sum == mul_move_pkg::WORD_RESET;
      c_q <= carry;
      v_q <= v_q | ovf;
    end else if (go && is_st && loc_acc) begin
      if (loc_target_in == mul_move_pkg::LOC_ACC_UPPER) begin
        acc_q[31:16] <= mul_q[31:16];
      end else begin
        acc_q[15:0] <= mul_q[31:16];
      end
      n_q <= mul_q[16 + mul_move_pkg::SIGN16];
      z_q <= mul_q[31:16] == mul_move_pkg::HALF_ZERO;
    end else if (avs_write_in && !wait_q && avs_address_in == mul_move_pkg::REG_ACC) begin
      acc_q <= merge(acc_q, avs_writedata_in, avs_byteenable_in);
    end
  end

  // auxiliary pointer registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int i = 0; i < 8; i++) begin
        aux_q[i] <= mul_move_pkg::WORD_RESET;
      end
    end else if (go && is_pc) begin
      aux_q[instr_word_in[2:0]] <= {{(32 - mul_move_pkg::PC_W){1'b0}}, pc_in};
    end
  end

  // memory store strobe and execution status pulses
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mem_wr_q <= 1'b0;
      mem_wdata_q <= mul_move_pkg::HALF_ZERO;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      mem_wr_q <= go && is_st && !loc_acc;
      if (go && is_st) begin
        mem_wdata_q <= mul_q[31:16];
      end
      done_q <= go || (state_q == mul_move_pkg::ST_REPEAT);
      illegal_q <= accept && bad;
    end
  end

  // bus slave: one wait cycle, then the request is taken
  logic [31:0] rd_d;
  always_comb begin
    rd_d = mul_move_pkg::WORD_RESET;
    if (avs_address_in[7:5] == mul_move_pkg::REG_AUX_HI && avs_address_in[1:0] == 2'b00) begin
      rd_d = aux_q[avs_address_in[4:2]];
    end else begin
      unique case (avs_address_in)
        mul_move_pkg::REG_CTRL: rd_d = {31'h0, mode_q};
        mul_move_pkg::REG_STATUS: rd_d = {16'h0, rpt_q, 3'h0, ~ready_q, v_q, c_q, z_q, n_q};
        mul_move_pkg::REG_ACC: rd_d = acc_q;
        mul_move_pkg::REG_PROD: rd_d = prod_q;
        mul_move_pkg::REG_MUL: rd_d = mul_q;
        mul_move_pkg::REG_SHIFT: rd_d = {16'h0, 2'h0, ovf_q, 5'h00, shift_q};
        default: rd_d = mul_move_pkg::WORD_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wait_q <= 1'b1;
      rdata_q <= mul_move_pkg::WORD_RESET;
      mode_q <= 1'b0;
    end else begin
      wait_q <= !((avs_read_in || avs_write_in) && wait_q);
      if (avs_read_in && wait_q) begin
        rdata_q <= rd_d;
      end
      if (avs_write_in && !wait_q && avs_address_in == mul_move_pkg::REG_CTRL
          && avs_byteenable_in[0]) begin
        mode_q <= avs_writedata_in[mul_move_pkg::CTRL_MODE_BIT];
      end
    end
  end

  assign instr_ready_out = ready_q;
  assign mem_wr_out = mem_wr_q;
  assign mem_wdata_out = mem_wdata_q;
  assign neg_flag_out = n_q;
  assign zero_flag_out = z_q;
  assign carry_flag_out = c_q;
  assign ovf_flag_out = v_q;
  assign exec_done_out = done_q;
  assign illegal_out = illegal_q;
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;

  // checks
  a_store_mem: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && is_st && !loc_acc |=> mem_wr_q && mem_wdata_q == $past(mul_q[31:16]))
    else $error("store did not write multiplicand upper half");
  a_store_flags: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && is_st && loc_acc |=> n_q == $past(mul_q[31])
      && z_q == ($past(mul_q[31:16]) == 16'h0000)
      && $past(mul_q[31:16]) == ($past(loc_target_in) == mul_move_pkg::LOC_ACC_UPPER
                                 ? acc_q[31:16] : acc_q[15:0]))
    else $error("store flags wrong");
  a_nonrep_once: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && !is_load_mul_add_op |=> rpt_q == 8'h00 && ready_q)
    else $error("non-repeatable move left repeat count");
  a_ovf_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && is_ovc |=> ovf_q == $past(src16[15:10]) && $stable({n_q, z_q, c_q, v_q}))
    else $error("overflow count load wrong");
  a_prod_upper: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && is_ph |=> prod_q[31:16] == $past(src16) && $stable(prod_q[15:0]) && ready_q)
    else $error("product upper load wrong");
  a_prod_lower: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && is_pl |=> prod_q[15:0] == $past(src16) && $stable(prod_q[31:16]))
    else $error("product lower load wrong");
  a_shift_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && is_pm |=> shift_q == ($past(instr_word_in[0]) ? $past(acc_q[18:16])
                                                         : $past(acc_q[2:0])))
    else $error("shift setting load wrong");
  a_mul_upper: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && is_t |=> mul_q[31:16] == $past(src16) && $stable({n_q, z_q, c_q, v_q}))
    else $error("multiplicand upper load wrong");
  a_mul_lower: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && is_tl |=> mul_q[15:0] == 16'h0 && $stable(mul_q[31:16]))
    else $error("multiplicand lower not cleared");
  a_aux_pc: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && is_pc |=> aux_q[$past(instr_word_in[2:0])] == {10'h0, $past(pc_in)})
    else $error("aux register did not take program counter");
  a_repeat_len: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && is_load_mul_add_op && rpt_q == 8'h02 |=> !ready_q [*2] ##1 ready_q)
    else $error("repeat count gave wrong length");
  a_load_mul_add_op_add: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    go && is_load_mul_add_op |=> acc_q == $past(acc_q) + $past(shp))
    else $error("accumulate result wrong");
  a_shift_fill: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    shift_q == mul_move_pkg::SHIFT_LEFT1 |-> shp == {prod_q[30:0], 1'b0})
    else $error("product left shift fill wrong");
  a_shift_sign: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    shift_q > mul_move_pkg::SHIFT_NONE |-> shp[31] == prod_q[31])
    else $error("product right shift sign wrong");
endmodule // multiplier_register_moves

// ### pkg/mul_move_pkg.sv
// constants for the multiplier register move unit
// assumes one core clock; opcodes arrive already fetched, operand already read
package mul_move_pkg;
  // opcode fields, matched on the upper bits of the first word; OP_LOAD_OVF and OP_CLR_MUL_LO on the whole word
  localparam logic [7:0] OP_STORE_MUL_HI = 8'h21;
  localparam logic [7:0] OP_LOAD_PROD_HI = 8'h2f;
  localparam logic [7:0] OP_LOAD_PROD_LO = 8'h27;
  localparam logic [7:0] OP_LOAD_MUL_HI = 8'h2d;
  localparam logic [7:0] OP_LOAD_MUL_ADD = 8'h10;
  localparam logic [15:0] OP_LOAD_OVF = 16'h5602;
  localparam logic [7:0] EXT_PREFIX = 8'h00;
  localparam logic [15:0] OP_CLR_MUL_LO = 16'h5656;
  localparam logic [14:0] OP_LOAD_SHIFT = 15'h2b1c;
  localparam logic [12:0] OP_SAVE_PC = 13'h07cb;
  // field positions
  localparam int HALF_SEL_BIT = 0;
  localparam int OVF_MSB = 15;
  localparam int OVF_LSB = 10;
  localparam int SIGN16 = 15;
  localparam int PC_W = 22;
  // product shift settings: 0 shifts left one, 1 none, 2..7 arithmetic right by code-1
  localparam logic [2:0] SHIFT_LEFT1 = 3'h0;
  localparam logic [2:0] SHIFT_NONE = 3'h1;
  localparam logic [2:0] SHIFT_RESET = 3'h0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [5:0] OVF_RESET = 6'h00;
  localparam logic [15:0] HALF_ZERO = 16'h0000;
  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_PROD = 8'h0c;
  localparam logic [7:0] REG_MUL = 8'h10;
  localparam logic [7:0] REG_SHIFT = 8'h14;
  localparam logic [2:0] REG_AUX_HI = 3'h1; // aux registers at 0x20 + 4*n
  localparam int CTRL_MODE_BIT = 0;
  // operand target as told by the addressing-mode decoder
  typedef enum logic [1:0] {
    LOC_MEM = 2'b00,
    LOC_ACC_LOWER = 2'b01,
    LOC_ACC_UPPER = 2'b10
  } loc_target_e;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_REPEAT = 1'b1
  } exec_state_e;
endpackage

// ### tb/core_data_model.sv
// partner model: the core data word read as operand and the store target
// assumes the unit's store strobe and data change on the rising edge of clk_sys_in
`timescale 1ns/100ps
module core_data_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [15:0] value_in,
  input wire logic mem_wr_in,
  input wire logic [15:0] mem_wdata_in,
  output logic [15:0] operand_data_out,
  output logic [15:0] stored_word_out,
  output logic [7:0] store_count_out
);
  logic [15:0] stored_word_q;
  logic [7:0] store_count_q;
  // the addressed memory word, presented for every execution cycle
  assign operand_data_out = value_in;
  assign stored_word_out = stored_word_q;
  assign store_count_out = store_count_q;
  // capture each store so the bench can see what landed and how often
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      stored_word_q <= 16'h0000;
      store_count_q <= 8'h00;
    end else if (mem_wr_in) begin
      stored_word_q <= mem_wdata_in;
      store_count_q <= store_count_q + 8'h01;
    end
  end
endmodule // core_data_model

// ### tb/tb_top.sv
// self-checking bench for the multiplier register move unit
// assumes the unit's hand-over timing: one wait cycle on the bus, effects one cycle after taking
`timescale 1ns/100ps
module tb_top;
  logic clk_sys_in, rst_in, valid, rpt_load, avs_read, avs_write;
  logic [15:0] word, ext, mem_value, operand, stored;
  logic [1:0] target;
  logic [21:0] pc;
  logic [7:0] rpt_count, avs_address, store_count;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic ready, mem_wr, neg_flag, zero_flag, carry_flag, ovf_flag, done, illegal, waitreq;
  logic [15:0] mem_wdata;
  int miscompares = 0, checks = 0, dones, illegals;
  // clock at 100 MHz
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  multiplier_register_moves multiplier_register_moves_inst (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .instr_valid_in(valid), .instr_word_in(word), .instr_ext_in(ext),
    .loc_target_in(target), .operand_data_in(operand), .pc_in(pc), .rpt_load_in(rpt_load),
    .rpt_count_in(rpt_count), .instr_ready_out(ready), .mem_wr_out(mem_wr),
    .mem_wdata_out(mem_wdata), .neg_flag_out(neg_flag), .zero_flag_out(zero_flag),
    .carry_flag_out(carry_flag), .ovf_flag_out(ovf_flag),
    .exec_done_out(done), .illegal_out(illegal),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_byteenable_in(avs_byteenable),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(waitreq));
  core_data_model core_data_model_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .value_in(mem_value), .mem_wr_in(mem_wr), .mem_wdata_in(mem_wdata),
    .operand_data_out(operand), .stored_word_out(stored), .store_count_out(store_count));
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // compare one value against its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // bus cycle: hold the request until the rising edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    i = 0;
    do begin
      @(posedge clk_sys_in);
      i++;
    end while (waitreq !== 1'b0 && i < 50);
    if (waitreq !== 1'b0) begin
      miscompares++;
      finish_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys_in); // idle edge so a following request never rewrites a strobe at once
  endtask
  // issue one instruction, then count done and illegal pulses while it runs out
  task automatic instr(input logic [15:0] w, input logic [1:0] t, input logic [15:0] d);
    int i;
    valid <= 1'b1;
    word <= w;
    target <= t;
    mem_value <= d;
    i = 0;
    do begin
      @(negedge clk_sys_in);
      i++;
    end while (ready !== 1'b1 && i < 50);
    if (i >= 50) begin
      miscompares++;
      finish_test();
    end
    @(posedge clk_sys_in);
    valid <= 1'b0;
    dones = 0;
    illegals = 0;
    repeat (8) begin
      @(negedge clk_sys_in);
      dones += (done === 1'b1);
      illegals += (illegal === 1'b1);
    end
    @(posedge clk_sys_in);
  endtask
  // repeat prefix with count n, taken while idle
  task automatic prefix(input logic [7:0] n);
    rpt_load <= 1'b1;
    rpt_count <= n;
    @(posedge clk_sys_in);
    rpt_load <= 1'b0;
  endtask
  // set the shift code through the accumulator lower half
  task automatic set_shift(input logic [2:0] code);
    bus(1'b1, mul_move_pkg::REG_ACC, {29'h0, code});
    instr(16'h5638, 2'b00, 16'h0000);
  endtask
  // product halves, multiplicand halves, refusal in mode 0
  task automatic test_loads();
    instr(16'h5656, 2'b00, 16'h0000);
    chk(illegals, 1, "mode 0 refusal");
    bus(1'b1, mul_move_pkg::REG_CTRL, 32'h0000_0001);
    instr(16'h2f00, 2'b00, 16'h1234);
    chk(dones, 1, "one execution");
    instr(16'h2700, 2'b00, 16'h5678);
    bus(1'b0, mul_move_pkg::REG_PROD, 32'h0);
    chk(rd, 32'h1234_5678, "product");
    instr(16'h2f00, 2'b00, 16'h9abc);
    bus(1'b0, mul_move_pkg::REG_PROD, 32'h0);
    chk(rd, 32'h9abc_5678, "product upper only");
    instr(16'h2d00, 2'b00, 16'h8000);
    instr(16'h5656, 2'b00, 16'h0000);
    bus(1'b0, mul_move_pkg::REG_MUL, 32'h0);
    chk(rd, 32'h8000_0000, "multiplicand");
    $display("test loads done");
  endtask
  // stores to memory and to accumulator halves
  task automatic test_stores();
    instr(16'h2100, 2'b00, 16'h0000);
    chk({store_count, stored}, {8'h01, 16'h8000}, "stored word");
    instr(16'h2100, 2'b01, 16'h0000);
    chk({neg_flag, zero_flag}, 2'b10, "flags negative");
    bus(1'b0, mul_move_pkg::REG_ACC, 32'h0);
    chk(rd[15:0], 16'h8000, "acc lower");
    instr(16'h2d00, 2'b00, 16'h0000);
    instr(16'h2100, 2'b10, 16'h0000);
    chk({neg_flag, zero_flag, store_count}, {2'b01, 8'h01}, "flags zero");
    $display("test stores done");
  endtask
  // overflow count, shift setting, saved program counter, repeat clearing
  task automatic test_misc();
    ext <= 16'h0000;
    instr(16'h5602, 2'b00, 16'ha7ff);
    bus(1'b0, mul_move_pkg::REG_SHIFT, 32'h0);
    chk(rd[13:8], 6'h29, "overflow count");
    bus(1'b1, mul_move_pkg::REG_ACC, 32'h0003_0006);
    instr(16'h5638, 2'b00, 16'h0000);
    bus(1'b0, mul_move_pkg::REG_SHIFT, 32'h0);
    chk(rd[2:0], 3'h6, "shift from lower");
    instr(16'h5639, 2'b00, 16'h0000);
    bus(1'b0, mul_move_pkg::REG_SHIFT, 32'h0);
    chk(rd[2:0], 3'h3, "shift from upper");
    pc <= 22'h3abcde;
    instr(16'h3e5b, 2'b00, 16'h0000);
    bus(1'b0, 8'h2c, 32'h0);
    chk(rd, 32'h003a_bcde, "saved pc");
    prefix(8'h05);
    instr(16'h2f00, 2'b00, 16'h0000);
    bus(1'b0, mul_move_pkg::REG_STATUS, 32'h0);
    chk(dones, 1, "single execution");
    chk(rd[15:8], 8'h00, "repeat cleared");
    $display("test misc done");
  endtask
  // repeated load-multiply-add and product shifting
  task automatic test_mac();
    set_shift(3'h1);
    instr(16'h2f00, 2'b00, 16'h0000);
    instr(16'h2700, 2'b00, 16'h0011);
    bus(1'b1, mul_move_pkg::REG_ACC, 32'h0000_0100);
    prefix(8'h02);
    instr(16'h1000, 2'b00, 16'h0001);
    chk(dones, 3, "repeat executions");
    bus(1'b0, mul_move_pkg::REG_ACC, 32'h0);
    chk(rd, 32'h0000_0133, "accumulated");
    set_shift(3'h0);
    bus(1'b1, mul_move_pkg::REG_ACC, 32'h0000_0000);
    instr(16'h1000, 2'b00, 16'h0001);
    bus(1'b0, mul_move_pkg::REG_ACC, 32'h0);
    chk(rd, 32'h0000_0022, "left shift");
    set_shift(3'h2);
    instr(16'h2f00, 2'b00, 16'hffff);
    instr(16'h2700, 2'b00, 16'hfff0);
    bus(1'b1, mul_move_pkg::REG_ACC, 32'h0000_0000);
    instr(16'h1000, 2'b00, 16'h0001);
    bus(1'b0, mul_move_pkg::REG_ACC, 32'h0);
    chk(rd, 32'hffff_fff8, "right shift");
    bus(1'b1, mul_move_pkg::REG_ACC, 32'h8000_0000);
    instr(16'h1000, 2'b00, 16'h0001);
    chk({carry_flag, ovf_flag}, 2'b11, "carry and overflow");
    bus(1'b0, mul_move_pkg::REG_ACC, 32'h0);
    chk(rd, 32'h7fff_fff8, "wrapped sum");
    bus(1'b0, mul_move_pkg::REG_SHIFT, 32'h0);
    chk(rd[13:8], 6'h28, "overflow count down");
    $display("test mac done");
  endtask
  // main sequence
  initial begin
    rst_in = 1'b1;
    {valid, rpt_load, avs_read, avs_write} = 4'h0;
    {word, ext, mem_value} = 48'h0;
    target = 2'b00;
    pc = 22'h0;
    rpt_count = 8'h00;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    test_loads();
    test_stores();
    test_misc();
    test_mac();
    finish_test();
  end
endmodule // tb_top
